//--- rtl/ddr3_access_defs.svh
// Functional notes
// - Write-data-ready rises after variable delay.
// - Write data sampled one or two cycles later.
// - Ready-to-data delay defaults to one cycle.
// - Closed bank gets ACTIVE before write.
// - Other row open: PRECHARGE, ACTIVE, then write.
// - Row already open: write command only.
// - Write-autoclose issues write with auto precharge.
// - Read data returned with read-valid strobe.
// - Reads use the same row checking.
// - Read-autoclose issues read with auto precharge.
// - Refresh burst of one to eight commands.
// - Internal timer period is interval times count.
// - Precharge only before first refresh of burst.
// - External request port disables internal timer.
// - External burst completion pulses acknowledge.
// - Address width is column, row, bank-select.
// - Bank address field is three bits.
// - Chip-select field is zero, one or two bits.
// - Address packed column, bank, chip select, row.
// - Command-ready pulses; valid counts only then.
`ifndef DDR3_ACCESS_DEFS_SVH
`define DDR3_ACCESS_DEFS_SVH

// User command codes.
`define UCMD_READ 4'h1
`define UCMD_WRITE 4'h2
`define UCMD_READ_AUTOCLOSE 4'h3
`define UCMD_WRITE_AUTOCLOSE 4'h4

// Address geometry defaults.
`define BANK_ADDR_BITS 3
`define COL_BITS_DEFAULT 11
`define ROW_BITS_DEFAULT 14
`define CS_BITS_DEFAULT 1
`define DATA_BITS_DEFAULT 64

// Write data path.
`define READY_TO_PAYLOAD_DELAY 1
`define WDATA_FIFO_DEPTH 16

// Refresh defaults.
`define REFRESH_BURST_DEFAULT 8
`define REFRESH_INTERVAL_CYC 780

// Timing in nanoseconds and derived clock counts, rounded up.
`define CLK_PERIOD_NS 10
`define CMD_GAP_NS 15
`define REF_GAP_NS 160
`define CMD_GAP_CYC ((`CMD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_GAP_CYC ((`REF_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- rtl/ddr3_access_pkg.sv
package ddr3_access_pkg;

  // Controller states, one-hot.
  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_CHECK = 10'h002,
    S_PRE   = 10'h004,
    S_ACT   = 10'h008,
    S_WREQ  = 10'h010,
    S_WRDY  = 10'h020,
    S_ISSUE = 10'h040,
    S_RPRE  = 10'h080,
    S_REF   = 10'h100,
    S_RDONE = 10'h200
  } state_t;

  // Memory-side command codes.
  typedef enum logic [3:0] {
    MC_NOP       = 4'h0,
    MC_ACTIVE    = 4'h1,
    MC_PRECHARGE = 4'h2,
    MC_PRE_ALL   = 4'h3,
    MC_WRITE     = 4'h4,
    MC_WRITE_AC  = 4'h5,
    MC_READ      = 4'h6,
    MC_READ_AC   = 4'h7,
    MC_REFRESH   = 4'h8
  } mem_cmd_t;

endpackage

//--- rtl/sync_fifo.sv
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
  } fifo_t;

  fifo_t st_reg;
  fifo_t st_next;
  logic push;
  logic pop;

  // Handshakes on both sides; full and empty follow the occupancy count.
  assign inReady = (st_reg.count != FULL);
  assign outValid = (st_reg.count != '0);
  assign outData = st_reg.mem[st_reg.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointer and storage update; pointers wrap at the last entry.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr = (st_reg.wrPtr == LAST) ? '0 : st_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      st_next.rdPtr = (st_reg.rdPtr == LAST) ? '0 : st_reg.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- rtl/ddr3_user_access_refresh.sv
`include "ddr3_access_defs.svh"

module ddr3_user_access_refresh #(
  parameter int COL_BITS = `COL_BITS_DEFAULT,
  parameter int ROW_BITS = `ROW_BITS_DEFAULT,
  parameter int CS_BITS = `CS_BITS_DEFAULT,
  parameter int DATA_BITS = `DATA_BITS_DEFAULT,
  parameter int READY_TO_PAYLOAD_DELAY = `READY_TO_PAYLOAD_DELAY,
  parameter int REFRESH_BURST = `REFRESH_BURST_DEFAULT,
  parameter int REFRESH_INTERVAL_PARAM = `REFRESH_INTERVAL_CYC,
  parameter bit EXT_REFRESH_PORT = 1'b0,
  parameter int FIFO_DEPTH = `WDATA_FIFO_DEPTH,
  localparam int BANK_SELECT_BITS = `BANK_ADDR_BITS + CS_BITS,
  localparam int ADDR_BITS = COL_BITS + ROW_BITS + BANK_SELECT_BITS
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic cmdRdy,
  input wire logic cmdValid,
  input wire logic [3:0] cmd,
  input wire logic [ADDR_BITS-1:0] addr,
  output logic dataInRdy,
  input wire logic [DATA_BITS-1:0] writeData,
  input wire logic [DATA_BITS/8-1:0] dataMask,
  output logic [DATA_BITS-1:0] readData,
  output logic readDataValid,
  input wire logic extAutoRef,
  output logic extAutoRefAck,
  output logic memCmdValid,
  output ddr3_access_pkg::mem_cmd_t memCmd,
  output logic [BANK_SELECT_BITS-1:0] memBankSel,
  output logic [ROW_BITS-1:0] memRow,
  output logic [COL_BITS-1:0] memCol,
  output logic memWrValid,
  output logic [DATA_BITS-1:0] memWrData,
  output logic [DATA_BITS/8-1:0] memWrMask,
  input wire logic memWrReady,
  input wire logic memRdValid,
  input wire logic [DATA_BITS-1:0] memRdData
);

  localparam int NBS = 1 << BANK_SELECT_BITS;
  localparam int MW = DATA_BITS / 8;
  localparam int FW = DATA_BITS + MW;
  localparam logic [31:0] REF_PERIOD =
    32'(REFRESH_INTERVAL_PARAM * REFRESH_BURST);
  localparam logic [7:0] CMD_GAP = 8'(`CMD_GAP_CYC);
  localparam logic [7:0] REF_GAP = 8'(`REF_GAP_CYC);
  localparam logic [3:0] BURST = 4'(REFRESH_BURST);
  localparam logic [1:0] RDLY = 2'(READY_TO_PAYLOAD_DELAY);

  typedef struct packed {
    ddr3_access_pkg::state_t state;
    logic cmdRdy;
    logic [3:0] cmd;
    logic [ADDR_BITS-1:0] addr;
    logic dataInRdy;
    logic [1:0] dly;
    logic [7:0] gap;
    logic [NBS-1:0] openValid;
    logic [NBS-1:0][ROW_BITS-1:0] openRow;
    logic [31:0] refTimer;
    logic refPending;
    logic [3:0] refLeft;
    logic extPrev;
    logic extAck;
    logic memCmdValid;
    ddr3_access_pkg::mem_cmd_t memCmd;
    logic [BANK_SELECT_BITS-1:0] memBankSel;
    logic [ROW_BITS-1:0] memRow;
    logic [COL_BITS-1:0] memCol;
    logic [DATA_BITS-1:0] readData;
    logic readDataValid;
  } ctrl_t;

  ctrl_t r_reg;
  ctrl_t r_next;
  logic fifoInReady;
  logic fifoPush;
  logic [FW-1:0] fifoOut;
  logic [COL_BITS-1:0] reqCol;
  logic [BANK_SELECT_BITS-1:0] reqSel;
  logic [ROW_BITS-1:0] reqRow;
  logic reqWrite;
  logic reqRead;
  logic reqClose;
  logic refTick;
  logic extRise;

  // Flat address split: column low, then bank, chip select, row on top.
  assign reqCol = r_reg.addr[COL_BITS-1:0];
  assign reqSel = r_reg.addr[COL_BITS +: BANK_SELECT_BITS];
  assign reqRow = r_reg.addr[COL_BITS+BANK_SELECT_BITS +: ROW_BITS];

  // Decode of the latched user command.
  assign reqWrite = (r_reg.cmd == `UCMD_WRITE) ||
                    (r_reg.cmd == `UCMD_WRITE_AUTOCLOSE);
  assign reqRead = (r_reg.cmd == `UCMD_READ) ||
                   (r_reg.cmd == `UCMD_READ_AUTOCLOSE);
  assign reqClose = (r_reg.cmd == `UCMD_WRITE_AUTOCLOSE) ||
                    (r_reg.cmd == `UCMD_READ_AUTOCLOSE);

  // Refresh triggers: the timer only without the external port.
  assign refTick = !EXT_REFRESH_PORT &&
                   (r_reg.refTimer == REF_PERIOD - 32'h1);
  assign extRise = EXT_REFRESH_PORT && extAutoRef && !r_reg.extPrev;

  // Write data enters the buffer a fixed delay after the ready pulse.
  assign fifoPush = (r_reg.state == ddr3_access_pkg::S_WRDY) &&
                    (r_reg.dly == RDLY);

  // Next-state logic of the access engine and refresh scheduler.
  always_comb begin
    r_next = r_reg;
    r_next.cmdRdy = 1'b0;
    r_next.dataInRdy = 1'b0;
    r_next.memCmdValid = 1'b0;
    r_next.extAck = 1'b0;
    r_next.extPrev = extAutoRef;
    r_next.readDataValid = memRdValid;
    if (memRdValid) begin
      r_next.readData = memRdData;
    end
    if (r_reg.gap != 8'h00) begin
      r_next.gap = r_reg.gap - 8'h01;
    end
    if (EXT_REFRESH_PORT || refTick) begin
      r_next.refTimer = 32'h0;
    end else begin
      r_next.refTimer = r_reg.refTimer + 32'h1;
    end
    unique case (r_reg.state)
      ddr3_access_pkg::S_IDLE: begin
        if (r_reg.cmdRdy && cmdValid) begin
          r_next.cmd = cmd;
          r_next.addr = addr;
          r_next.state = ddr3_access_pkg::S_CHECK;
        end else if (r_reg.refPending) begin
          r_next.state = ddr3_access_pkg::S_RPRE;
        end else if (!r_reg.cmdRdy) begin
          r_next.cmdRdy = 1'b1;
        end
      end
      ddr3_access_pkg::S_CHECK: begin
        if (!(reqWrite || reqRead)) begin
          r_next.state = ddr3_access_pkg::S_IDLE;
        end else if (r_reg.openValid[reqSel] &&
                     r_reg.openRow[reqSel] == reqRow) begin
          r_next.state = reqWrite ? ddr3_access_pkg::S_WREQ :
                                    ddr3_access_pkg::S_ISSUE;
        end else if (r_reg.openValid[reqSel]) begin
          r_next.state = ddr3_access_pkg::S_PRE;
        end else begin
          r_next.state = ddr3_access_pkg::S_ACT;
        end
      end
      ddr3_access_pkg::S_PRE: begin
        if (r_reg.gap == 8'h00) begin
          r_next.memCmdValid = 1'b1;
          r_next.memCmd = ddr3_access_pkg::MC_PRECHARGE;
          r_next.memBankSel = reqSel;
          r_next.openValid[reqSel] = 1'b0;
          r_next.gap = CMD_GAP;
          r_next.state = ddr3_access_pkg::S_ACT;
        end
      end
      ddr3_access_pkg::S_ACT: begin
        if (r_reg.gap == 8'h00) begin
          r_next.memCmdValid = 1'b1;
          r_next.memCmd = ddr3_access_pkg::MC_ACTIVE;
          r_next.memBankSel = reqSel;
          r_next.memRow = reqRow;
          r_next.openValid[reqSel] = 1'b1;
          r_next.openRow[reqSel] = reqRow;
          r_next.gap = CMD_GAP;
          r_next.state = reqWrite ? ddr3_access_pkg::S_WREQ :
                                    ddr3_access_pkg::S_ISSUE;
        end
      end
      ddr3_access_pkg::S_WREQ: begin
        // Ready is offered only while the buffer has room for the word.
        if (fifoInReady) begin
          r_next.dataInRdy = 1'b1;
          r_next.dly = 2'h0;
          r_next.state = ddr3_access_pkg::S_WRDY;
        end
      end
      ddr3_access_pkg::S_WRDY: begin
        r_next.dly = r_reg.dly + 2'h1;
        if (fifoPush) begin
          r_next.state = ddr3_access_pkg::S_ISSUE;
        end
      end
      ddr3_access_pkg::S_ISSUE: begin
        if (r_reg.gap == 8'h00) begin
          r_next.memCmdValid = 1'b1;
          if (reqWrite) begin
            r_next.memCmd = reqClose ? ddr3_access_pkg::MC_WRITE_AC :
                                       ddr3_access_pkg::MC_WRITE;
          end else begin
            r_next.memCmd = reqClose ? ddr3_access_pkg::MC_READ_AC :
                                       ddr3_access_pkg::MC_READ;
          end
          r_next.memBankSel = reqSel;
          r_next.memRow = reqRow;
          r_next.memCol = reqCol;
          if (reqClose) begin
            r_next.openValid[reqSel] = 1'b0;
          end
          r_next.gap = CMD_GAP;
          r_next.state = ddr3_access_pkg::S_IDLE;
        end
      end
      ddr3_access_pkg::S_RPRE: begin
        if (r_reg.gap == 8'h00) begin
          r_next.memCmdValid = 1'b1;
          r_next.memCmd = ddr3_access_pkg::MC_PRE_ALL;
          r_next.openValid = '0;
          r_next.refLeft = BURST;
          r_next.gap = CMD_GAP;
          r_next.state = ddr3_access_pkg::S_REF;
        end
      end
      ddr3_access_pkg::S_REF: begin
        if (r_reg.gap == 8'h00) begin
          r_next.memCmdValid = 1'b1;
          r_next.memCmd = ddr3_access_pkg::MC_REFRESH;
          r_next.refLeft = r_reg.refLeft - 4'h1;
          r_next.gap = REF_GAP;
          if (r_reg.refLeft == 4'h1) begin
            r_next.state = ddr3_access_pkg::S_RDONE;
          end
        end
      end
      ddr3_access_pkg::S_RDONE: begin
        if (r_reg.gap == 8'h00) begin
          r_next.extAck = EXT_REFRESH_PORT;
          r_next.refPending = 1'b0;
          r_next.state = ddr3_access_pkg::S_IDLE;
        end
      end
    endcase
    // A new trigger in the clearing cycle keeps the request pending.
    if (refTick || extRise) begin
      r_next.refPending = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.state <= ddr3_access_pkg::S_IDLE;
      r_reg.memCmd <= ddr3_access_pkg::MC_NOP;
    end else begin
      r_reg <= r_next;
    end
  end

  // Write data and its mask travel together through the buffer.
  sync_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wdata_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(fifoPush),
    .inData({dataMask, writeData}),
    .inReady(fifoInReady),
    .outValid(memWrValid),
    .outData(fifoOut),
    .outReady(memWrReady)
  );

  assign memWrData = fifoOut[DATA_BITS-1:0];
  assign memWrMask = fifoOut[FW-1:DATA_BITS];

  // Registered outputs.
  assign cmdRdy = r_reg.cmdRdy;
  assign dataInRdy = r_reg.dataInRdy;
  assign readData = r_reg.readData;
  assign readDataValid = r_reg.readDataValid;
  assign extAutoRefAck = r_reg.extAck;
  assign memCmdValid = r_reg.memCmdValid;
  assign memCmd = r_reg.memCmd;
  assign memBankSel = r_reg.memBankSel;
  assign memRow = r_reg.memRow;
  assign memCol = r_reg.memCol;

endmodule

//--- sim/ddr3_user_access_refresh_asserts.sv
module ddr3_user_access_refresh_asserts #(
  parameter int DATA_BITS = 64,
  parameter bit EXT_REFRESH_PORT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdRdy,
  input wire logic dataInRdy,
  input wire logic [DATA_BITS-1:0] readData,
  input wire logic readDataValid,
  input wire logic extAutoRefAck,
  input wire logic memCmdValid,
  input wire ddr3_access_pkg::mem_cmd_t memCmd,
  input wire logic memRdValid,
  input wire logic [DATA_BITS-1:0] memRdData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Handshake strobes and memory commands stand for one cycle only.
  a_slot_pulse: assert property (cmdRdy |=> !cmdRdy)
    else $error("cmdRdy held two cycles");
  a_data_pulse: assert property (dataInRdy |=> !dataInRdy)
    else $error("dataInRdy held two cycles");
  a_cmd_gap: assert property (memCmdValid |=> !memCmdValid)
    else $error("memory commands too close");

  // Read data follows the memory return by one cycle.
  a_read_return: assert property (memRdValid |=>
    readDataValid && readData == $past(memRdData))
    else $error("read return not forwarded");
  a_read_cause: assert property (readDataValid |-> $past(memRdValid))
    else $error("readDataValid without memory return");

  // Internal refresh mode never acknowledges.
  a_ack_mode: assert property (!EXT_REFRESH_PORT |-> !extAutoRefAck)
    else $error("acknowledge in internal mode");

  // A refresh burst opens with one precharge-all, then spaced refreshes.
  a_pre_first: assert property (memCmdValid &&
    memCmd == ddr3_access_pkg::MC_PRE_ALL |-> ##[1:4]
    memCmdValid && memCmd == ddr3_access_pkg::MC_REFRESH)
    else $error("precharge-all not followed by refresh");
  a_ref_gap: assert property (memCmdValid &&
    memCmd == ddr3_access_pkg::MC_REFRESH |=> !memCmdValid [*8])
    else $error("command too soon after refresh");
endmodule

bind ddr3_user_access_refresh ddr3_user_access_refresh_asserts #(
  .DATA_BITS(DATA_BITS),
  .EXT_REFRESH_PORT(EXT_REFRESH_PORT)
) u_chk (.clk, .sys_rst, .cmdRdy, .dataInRdy, .readData, .readDataValid,
  .extAutoRefAck, .memCmdValid, .memCmd, .memRdValid, .memRdData);

//--- sim/mem_model.sv
module mem_model #(
  parameter int DATA_BITS = 64
) (
  input wire logic clk,
  input wire logic stall,
  input wire logic memCmdValid,
  input wire ddr3_access_pkg::mem_cmd_t memCmd,
  input wire logic memWrValid,
  input wire logic [DATA_BITS-1:0] memWrData,
  input wire logic [DATA_BITS/8-1:0] memWrMask,
  output logic memWrReady,
  output logic memRdValid,
  output logic [DATA_BITS-1:0] memRdData,
  output int popCount,
  output logic [DATA_BITS-1:0] lastWord,
  output logic [DATA_BITS/8-1:0] lastMask
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] rdDelay = 4'h0;

  initial begin
    memWrReady = 1'b1;
    memRdValid = 1'b0;
    memRdData = '0;
    popCount = 0;
    lastWord = '0;
    lastMask = '0;
  end

  // Words leave the FIFO whenever the memory is not stalling.
  always @(posedge clk) begin
    if (memWrValid && memWrReady) begin
      popCount <= popCount + 1;
      lastWord <= memWrData;
      lastMask <= memWrMask;
    end
  end

  // Reads return the last stored word; the bus scrambles when idle.
  always @(negedge clk) begin
    memWrReady <= !stall;
    memRdValid <= rdDelay == 4'h1;
    memRdData <= (rdDelay == 4'h1) ? lastWord : ~memRdData;
    if (memCmdValid && (memCmd == ddr3_access_pkg::MC_READ ||
        memCmd == ddr3_access_pkg::MC_READ_AC)) begin
      rdDelay <= 4'h3;
    end else if (rdDelay != 4'h0) begin
      rdDelay <= rdDelay - 4'h1;
    end
  end
endmodule

//--- sim/tb_ddr3_user_access_refresh.sv
module tb_ddr3_user_access_refresh;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RI = 400;
  localparam int RB = 3;
  logic clk = 0, sys_rst = 1, cmdValid = 0, extAutoRef = 0, stall = 0;
  logic [3:0] cmd = 4'h0;
  logic [28:0] addr = '0;
  logic [63:0] writeData = '0;
  logic [7:0] dataMask = 8'h00;
  logic cmdRdy, dataInRdy, readDataValid, extAutoRefAck, memCmdValid;
  logic memWrValid, memWrReady, memRdValid, got;
  logic [63:0] readData, memWrData, memRdData, lastWord, rdWord;
  logic [7:0] memWrMask, lastMask;
  logic xAck, xCmdValid;
  ddr3_access_pkg::mem_cmd_t xCmd;
  int xRef = 0, xPre = 0, xAckCount = 0;
  ddr3_access_pkg::mem_cmd_t memCmd;
  logic [3:0] memBankSel;
  logic [13:0] memRow;
  logic [10:0] memCol;
  logic [28:0] lastAddr;
  logic [3:0] log[$];
  int popCount, base, mismatches = 0, check_count = 0, cyc = 0;
  int refCount = 0, preAllCount = 0, lastPreAt = 0, period = 0;

  ddr3_user_access_refresh #(.REFRESH_BURST(RB),
    .REFRESH_INTERVAL_PARAM(RI)) u_dut (.clk, .sys_rst, .cmdRdy,
    .cmdValid, .cmd, .addr, .dataInRdy, .writeData, .dataMask, .readData,
    .readDataValid, .extAutoRef, .extAutoRefAck, .memCmdValid, .memCmd,
    .memBankSel, .memRow, .memCol, .memWrValid, .memWrData, .memWrMask,
    .memWrReady, .memRdValid, .memRdData);
  mem_model u_mem (.clk, .stall, .memCmdValid, .memCmd, .memWrValid,
    .memWrData, .memWrMask, .memWrReady, .memRdValid, .memRdData,
    .popCount, .lastWord, .lastMask);

  // Second engine in external refresh mode; only its refresh side is used.
  ddr3_user_access_refresh #(.REFRESH_BURST(RB),
    .REFRESH_INTERVAL_PARAM(RI), .EXT_REFRESH_PORT(1'b1)) u_ext (.clk,
    .sys_rst, .cmdRdy(), .cmdValid(1'b0), .cmd(4'h0), .addr(29'h0),
    .dataInRdy(), .writeData(64'h0), .dataMask(8'h00), .readData(),
    .readDataValid(), .extAutoRef, .extAutoRefAck(xAck),
    .memCmdValid(xCmdValid), .memCmd(xCmd), .memBankSel(), .memRow(),
    .memCol(), .memWrValid(), .memWrData(), .memWrMask(),
    .memWrReady(1'b1), .memRdValid(1'b0), .memRdData(64'h0));

  initial forever #5 clk = ~clk;

  // Logs memory commands and read returns mid-cycle, and cuts a hang short.
  always @(negedge clk) begin
    cyc++;
    if (xAck === 1'b1) xAckCount++;
    if (xCmdValid === 1'b1 && xCmd == ddr3_access_pkg::MC_REFRESH) xRef++;
    if (xCmdValid === 1'b1 && xCmd == ddr3_access_pkg::MC_PRE_ALL) xPre++;
    if (cyc > 20000) begin
      mismatches++;
      give_verdict();
    end
    if (readDataValid === 1'b1) rdWord = readData;
    if (memCmdValid === 1'b1) begin
      if (memCmd == ddr3_access_pkg::MC_REFRESH) begin
        refCount++;
      end else if (memCmd == ddr3_access_pkg::MC_PRE_ALL) begin
        preAllCount++;
        period = cyc - lastPreAt;
        lastPreAt = cyc;
      end else begin
        log.push_back(memCmd);
        lastAddr = {memRow, memBankSel, memCol};
      end
    end
  end

  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic issue(logic [3:0] c, logic [28:0] a);
    cmd = c;
    addr = a;
    cmdValid = 1'b1;
    // Ready is read mid-cycle; the next rising edge then takes the request.
    repeat (300) begin
      if (cmdRdy === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  task automatic wr(logic [3:0] c, logic [28:0] a, logic [63:0] d);
    writeData = d;
    dataMask = ~d[7:0];
    issue(c, a);
  endtask

  task automatic wait_rdy(int lim);
    got = 1'b0;
    repeat (lim) begin
      @(negedge clk);
      if (dataInRdy === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
    repeat (2) @(negedge clk);
  endtask

  // Compares the logged access commands, first in the low nibble.
  task automatic seq(string n, logic [11:0] e, int k);
    repeat (20) @(negedge clk);
    chk(n, k, log.size());
    for (int i = 0; i < k && i < log.size(); i++) chk(n, e[4*i+:4], log[i]);
    log.delete();
    $display("test %s done", n);
  endtask

  task automatic sync_ref();
    int p;
    p = preAllCount;
    repeat (1300) begin
      @(negedge clk);
      if (preAllCount != p) break;
    end
    repeat (70) @(negedge clk);
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    sync_ref();
    chk("ext idle refresh", 0, xRef);
    wr(4'h2, {14'd5, 4'h0, 11'd3}, 64'hC3C3_0000_1234_5678);
    wait_rdy(40);
    chk("write ready", 1, got);
    seq("closed write", 12'h041, 2);
    chk("address", {14'd5, 4'h0, 11'd3}, lastAddr);
    issue(4'h1, {14'd5, 4'h0, 11'd3});
    seq("hit read", 12'h006, 1);
    chk("read data", 64'hC3C3_0000_1234_5678, rdWord);
    wr(4'h2, {14'd6, 4'h0, 11'd9}, 64'h55);
    wait_rdy(40);
    seq("miss write", 12'h412, 3);
    issue(4'h1, {14'd7, 4'hA, 11'h7FF});
    seq("closed read", 12'h061, 2);
    chk("address", {14'd7, 4'hA, 11'h7FF}, lastAddr);
    issue(4'h1, {14'h8, 4'hA, 11'h7FF});
    seq("miss read", 12'h612, 3);
    sync_ref();
    wr(4'h4, {14'd2, 4'h1, 11'd0}, 64'h66);
    wait_rdy(40);
    seq("autoclose write", 12'h051, 2);
    wr(4'h2, {14'd2, 4'h1, 11'd0}, 64'h77);
    wait_rdy(40);
    seq("write after close", 12'h041, 2);
    issue(4'h3, {14'd2, 4'h1, 11'd1});
    seq("autoclose read", 12'h007, 1);
    issue(4'h1, {14'd2, 4'h1, 11'd1});
    seq("read after close", 12'h061, 2);
    issue(4'h5, {14'd2, 4'h1, 11'd1});
    seq("illegal code", 12'h000, 0);
    sync_ref();
    sync_ref();
    chk("refresh period", RI * RB, period);
    chk("burst size", RB * preAllCount, refCount);
    $display("test refresh done");
    stall = 1'b1;
    base = popCount;
    for (int i = 0; i < 17; i++) begin
      wr(4'h2, {14'd1, 4'h2, 11'(i)}, 64'(i));
      wait_rdy(40);
      chk("fill ready", i < 16, got);
    end
    stall = 1'b0;
    wait_rdy(80);
    chk("ready after drain", 1, got);
    repeat (40) @(negedge clk);
    chk("drained words", 17, popCount - base);
    chk("last word", 16, lastWord);
    chk("last mask", 8'hEF, lastMask);
    log.delete();
    $display("test fifo done");
    extAutoRef = 1'b1;
    repeat (100) @(negedge clk);
    extAutoRef = 1'b0;
    chk("ext acknowledge", 1, xAckCount);
    chk("ext burst size", RB, xRef);
    chk("ext precharge", 1, xPre);
    $display("test external refresh done");
    give_verdict();
  end
endmodule
